/* File: bpc_pkg.sv */
package bpc_pkg;
  // apb register byte offsets
  localparam logic [11:0] BPC_OFF_CTRL0 = 12'h500;
  localparam logic [11:0] BPC_OFF_CTRL1 = 12'h504;
  localparam logic [11:0] BPC_OFF_PAT_LO = 12'h508;
  localparam logic [11:0] BPC_OFF_PAT_HI = 12'h50C;
  localparam logic [11:0] BPC_OFF_BC0 = 12'h510;
  localparam logic [11:0] BPC_OFF_BC1 = 12'h514;
  localparam logic [11:0] BPC_OFF_EC0 = 12'h518;
  localparam logic [11:0] BPC_OFF_EC1 = 12'h51C;

  // tester_control_zero field positions
  localparam int BPC_C0_RESYNC = 0;
  localparam int BPC_C0_LATCH = 1;
  localparam int BPC_C0_PS_LSB = 2;
  localparam int BPC_C0_RXINV = 5;
  localparam int BPC_C0_TXINV = 6;
  localparam int BPC_C0_RPL_LSB = 8;
  localparam int BPC_C0_IE_OF = 13;
  localparam int BPC_C0_IE_BED = 14;
  localparam int BPC_C0_IE_SYNC = 15;
  // control one field positions
  localparam int BPC_C1_TXLOAD = 0;
  localparam int BPC_C1_ALT_LSB = 8;
  // error_count_low_and_flags status positions
  localparam int BPC_ST_SYNC = 0;
  localparam int BPC_ST_ERR_OVF = 1;
  localparam int BPC_ST_BIT_OVF = 2;
  localparam int BPC_ST_BIT_ERR = 3;
  localparam int BPC_ST_SYNC_CHG = 4;

  // reset values
  localparam logic [15:0] BPC_CTRL_RST = 16'h0000;
  localparam logic [31:0] BPC_PAT_RST = 32'h00000000;
  localparam logic [31:0] BPC_LFSR_SEED = 32'hFFFFFFFF;

  // pattern select codes
  localparam logic [2:0] BPC_PS_PRBS7 = 3'h0;
  localparam logic [2:0] BPC_PS_PRBS11 = 3'h1;
  localparam logic [2:0] BPC_PS_PRBS15 = 3'h2;
  localparam logic [2:0] BPC_PS_QRSS = 3'h3;
  localparam logic [2:0] BPC_PS_REP = 3'h4;
  localparam logic [2:0] BPC_PS_ALT = 3'h5;

  // repeat length minus one, the wrap point, is code plus this offset
  localparam logic [4:0] BPC_REP_LEN_M1_BASE = 5'h10;
  // checker lock and loss thresholds, in bits
  localparam logic [5:0] BPC_LOCK_GOOD = 6'h20;
  localparam logic [5:0] BPC_LOSS_WIN = 6'h3F;
  localparam logic [3:0] BPC_LOSS_ERRS = 4'h6;

  // pattern configuration shared by generator and checker reference
  typedef struct packed {
    logic [2:0] mode;
    logic [3:0] len_code;
    logic [31:0] pattern;
    logic [7:0] alt_cnt;
  } bpc_pat_cfg_t;
endpackage : bpc_pkg

/* File: bpc_edge_detect.sv */
`timescale 1ns/1ns
module bpc_edge_detect #(
  parameter int N = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // strobe levels in, rise pulses out
  input wire logic [N-1:0] level,
  output logic [N-1:0] rise
);
  import bpc_pkg::*;

  // one delay flop per strobe
  generate
    for (genvar i = 0; i < N; i++) begin : g_edge
      logic prev_reg; // last sampled level
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          prev_reg <= 1'b0;
        end else begin
          prev_reg <= level[i];
        end
      end
      // only a zero-to-one change fires; a held one stays quiet
      assign rise[i] = level[i] & ~prev_reg;
    end
  endgenerate
endmodule : bpc_edge_detect

/* File: bpc_pattern_src.sv */
`timescale 1ns/1ns
module bpc_pattern_src (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // sequencing
  input wire logic step,
  input wire logic load,
  // self-sync feed for pseudorandom modes
  input wire logic seed_en,
  input wire logic seed_bit,
  // configuration
  input wire bpc_pkg::bpc_pat_cfg_t cfg,
  // bit that goes out at the next step
  output logic bit_out
);
  import bpc_pkg::*;

  // feedback of the selected pseudorandom polynomial
  function automatic logic prbs_fb(input logic [2:0] m,
                                   input logic [31:0] s);
    case (m)
      BPC_PS_PRBS7: prbs_fb = s[6] ^ s[5];
      BPC_PS_PRBS11: prbs_fb = s[10] ^ s[8];
      BPC_PS_PRBS15: prbs_fb = s[14] ^ s[13];
      default: prbs_fb = s[19] ^ s[16];
    endcase
  endfunction : prbs_fb

  logic [31:0] sh_reg; // lfsr history
  logic [4:0] pos_reg; // bit index in word
  logic [7:0] rep_reg; // alternating word repeats
  logic word_sel_reg; // which alternating word

  wire is_prbs = cfg.mode < BPC_PS_REP;
  wire is_rep = cfg.mode == BPC_PS_REP;
  wire fb = prbs_fb(cfg.mode, sh_reg);
  // qrss: a long zero run is broken by a forced one
  wire qrss_force = (cfg.mode == BPC_PS_QRSS) &&
                    (sh_reg[13:0] == 14'h0000);
  wire [4:0] len_m1 = BPC_REP_LEN_M1_BASE + {1'b0, cfg.len_code};
  wire pos_wrap = is_rep ? (pos_reg == len_m1)
                         : (pos_reg[3:0] == 4'hF);
  wire alt_done = rep_reg == (cfg.alt_cnt - 8'h01);
  wire [4:0] alt_idx = {word_sel_reg, pos_reg[3:0]};
  wire rep_bit = cfg.pattern[pos_reg];
  wire alt_bit = cfg.pattern[alt_idx];
  wire [31:0] sh_next = {sh_reg[30:0], seed_en ? seed_bit : fb};

  // output select by mode; illegal codes fall to the alternating path
  assign bit_out = is_prbs ? (fb | qrss_force) :
                   is_rep ? rep_bit : alt_bit;

  // state advance on each bit step
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_reg <= BPC_LFSR_SEED;
      pos_reg <= 5'h00;
      rep_reg <= 8'h00;
      word_sel_reg <= 1'b0;
    end else if (load) begin
      // restart from a non-zero seed so the lfsr cannot stall
      sh_reg <= BPC_LFSR_SEED;
      pos_reg <= 5'h00;
      rep_reg <= 8'h00;
      word_sel_reg <= 1'b0;
    end else if (step) begin
      sh_reg <= sh_next;
      pos_reg <= pos_wrap ? 5'h00 : pos_reg + 5'h01;
      if (pos_wrap && !is_rep) begin
        rep_reg <= alt_done ? 8'h00 : rep_reg + 8'h01;
        word_sel_reg <= word_sel_reg ^ alt_done;
      end
    end
  end
endmodule : bpc_pattern_src

/* File: bpc_top.sv */
`timescale 1ns/1ns
module bpc_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit stream
  input wire logic tx_bit_en,
  output logic tx_data,
  // receive stream
  input wire logic rx_bit_en,
  input wire logic rx_data,
  // status out
  output logic rx_locked,
  output logic irq
);
  import bpc_pkg::*;

  typedef enum logic {SYNC_SEARCH, SYNC_LOCKED} bpc_sync_t;

  // software registers
  logic [15:0] ctrl0_reg; // tester_control_zero
  logic [15:0] ctrl1_reg; // tx load strobe, alt count
  logic [31:0] pat_reg; // repeat or alternating pattern
  logic [31:0] bc_snap_reg; // bit_count_snapshot
  logic [23:0] ec_snap_reg; // error_count_snapshot
  // bus answer flops
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  // checker state
  bpc_sync_t sync_reg, sync_next;
  logic [5:0] good_reg; // consecutive matches while searching
  logic [5:0] win_reg; // loss window position
  logic [3:0] bad_reg; // errors in current window
  logic [31:0] bit_cnt_reg; // running bit count
  logic [23:0] err_cnt_reg; // running error count
  // sticky status
  logic bit_ovf_reg, err_ovf_reg, bit_err_reg, sync_chg_reg;
  logic tx_data_reg;
  logic irq_reg;

  // control field breakout
  wire [2:0] ps_sel = ctrl0_reg[BPC_C0_PS_LSB +: 3];
  wire rx_inv = ctrl0_reg[BPC_C0_RXINV];
  wire tx_inv = ctrl0_reg[BPC_C0_TXINV];
  wire [3:0] rpl_code = ctrl0_reg[BPC_C0_RPL_LSB +: 4];
  wire ie_of = ctrl0_reg[BPC_C0_IE_OF];
  wire ie_bed = ctrl0_reg[BPC_C0_IE_BED];
  wire ie_sync = ctrl0_reg[BPC_C0_IE_SYNC];
  wire [7:0] alt_cnt = ctrl1_reg[BPC_C1_ALT_LSB +: 8];

  // apb phase decode
  wire acc = psel & penable & ~pready_reg; // access before answer
  wire done = psel & penable & pready_reg; // completing edge
  wire wr_done = done & pwrite;
  wire hit_c0 = paddr == BPC_OFF_CTRL0;
  wire hit_c1 = paddr == BPC_OFF_CTRL1;
  wire hit_plo = paddr == BPC_OFF_PAT_LO;
  wire hit_phi = paddr == BPC_OFF_PAT_HI;
  wire hit_bc0 = paddr == BPC_OFF_BC0;
  wire hit_bc1 = paddr == BPC_OFF_BC1;
  wire hit_ec0 = paddr == BPC_OFF_EC0;
  wire hit_ec1 = paddr == BPC_OFF_EC1;
  wire mapped = hit_c0 | hit_c1 | hit_plo | hit_phi |
                hit_bc0 | hit_bc1 | hit_ec0 | hit_ec1;
  // reading the flag word clears the sticky bits; the clear lands on
  // the edge that captures the word, so an event set on that edge
  // survives for the next read instead of being lost unseen
  wire st_clr = acc & ~pwrite & hit_ec0;

  // flag word: error count low byte over status bits
  wire [7:0] st_byte = {3'h0, sync_chg_reg, bit_err_reg, bit_ovf_reg,
                        err_ovf_reg, sync_reg == SYNC_LOCKED};
  wire [15:0] ec0_word = {ec_snap_reg[7:0], st_byte};
  wire [31:0] rd_word =
      hit_c0 ? {16'h0000, ctrl0_reg} :
      hit_c1 ? {16'h0000, ctrl1_reg} :
      hit_plo ? {16'h0000, pat_reg[15:0]} :
      hit_phi ? {16'h0000, pat_reg[31:16]} :
      hit_bc0 ? {16'h0000, bc_snap_reg[15:0]} :
      hit_bc1 ? {16'h0000, bc_snap_reg[31:16]} :
      hit_ec0 ? {16'h0000, ec0_word} :
      hit_ec1 ? {16'h0000, ec_snap_reg[23:8]} : 32'h00000000;

  // apb answer: one wait state, error on unmapped address
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= acc;
      pslverr_reg <= acc & ~mapped;
      if (acc) begin
        prdata_reg <= pwrite ? 32'h00000000 : rd_word;
      end
    end
  end

  // writable registers; snapshot words are read only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_reg <= BPC_CTRL_RST;
      ctrl1_reg <= BPC_CTRL_RST;
      pat_reg <= BPC_PAT_RST;
    end else if (wr_done) begin
      if (hit_c0) ctrl0_reg <= {pwdata[15:13], 1'b0, pwdata[11:8],
                               1'b0, pwdata[6:0]};
      if (hit_c1) ctrl1_reg <= {pwdata[15:8], 7'h00, pwdata[0]};
      if (hit_plo) pat_reg[15:0] <= pwdata[15:0];
      if (hit_phi) pat_reg[31:16] <= pwdata[15:0];
    end
  end

  // strobe edges: resync, latch, tx load; the edge comes from the
  // registered bit, so a held one never acts twice
  logic [2:0] strobe_rise;
  bpc_edge_detect #(.N(3)) u_edges (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .level({ctrl1_reg[BPC_C1_TXLOAD], ctrl0_reg[BPC_C0_LATCH],
            ctrl0_reg[BPC_C0_RESYNC]}),
    .rise(strobe_rise)
  );
  wire resync_rise = strobe_rise[0];
  wire latch_rise = strobe_rise[1];
  wire txload_rise = strobe_rise[2];

  // same configuration feeds both ends
  bpc_pat_cfg_t cfg;
  assign cfg = '{mode: ps_sel, len_code: rpl_code, pattern: pat_reg,
                 alt_cnt: alt_cnt};

  // generator
  logic gen_bit;
  bpc_pattern_src u_gen (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .step(tx_bit_en),
    .load(txload_rise),
    .seed_en(1'b0),
    .seed_bit(1'b0),
    .cfg(cfg),
    .bit_out(gen_bit)
  );

  // transmit bit register, inverted on request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_reg <= 1'b0;
    end else if (tx_bit_en) begin
      tx_data_reg <= gen_bit ^ tx_inv;
    end
  end

  // checker reference and compare
  wire rx_bit = rx_data ^ rx_inv;
  wire is_prbs = ps_sel < BPC_PS_REP;
  wire locked = sync_reg == SYNC_LOCKED;
  logic ref_bit;
  wire match = rx_bit == ref_bit;
  // pseudorandom search loads received bits into the lfsr;
  // pattern modes slip one bit on each miss while searching
  wire ref_step = rx_bit_en & (locked | is_prbs | match);
  bpc_pattern_src u_ref (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .step(ref_step),
    .load(resync_rise),
    .seed_en(is_prbs & ~locked),
    .seed_bit(rx_bit),
    .cfg(cfg),
    .bit_out(ref_bit)
  );

  // only a locked checker counts, so search noise never reaches the
  // host counters
  wire bit_seen = rx_bit_en & locked;
  wire err_seen = bit_seen & ~match;
  wire win_end = win_reg == BPC_LOSS_WIN;
  wire loss = err_seen & (bad_reg == BPC_LOSS_ERRS - 4'h1);
  wire gain = rx_bit_en & ~locked & match &
              (good_reg == BPC_LOCK_GOOD - 6'h01);

  // lock state choice
  always_comb begin
    sync_next = sync_reg;
    case (sync_reg)
      SYNC_SEARCH: if (gain) sync_next = SYNC_LOCKED;
      SYNC_LOCKED: if (loss) sync_next = SYNC_SEARCH;
      default: sync_next = SYNC_SEARCH;
    endcase
    if (resync_rise) sync_next = SYNC_SEARCH;
  end
  wire sync_flip = sync_next != sync_reg;

  // lock tracking counters
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= SYNC_SEARCH;
      good_reg <= 6'h00;
      win_reg <= 6'h00;
      bad_reg <= 4'h0;
    end else begin
      sync_reg <= sync_next;
      if (resync_rise || sync_flip) begin
        good_reg <= 6'h00;
        win_reg <= 6'h00;
        bad_reg <= 4'h0;
      end else if (rx_bit_en && !locked) begin
        good_reg <= match ? good_reg + 6'h01 : 6'h00;
      end else if (bit_seen) begin
        win_reg <= win_reg + 6'h01;
        bad_reg <= win_end ? 4'h0 : bad_reg + {3'h0, err_seen};
      end
    end
  end

  // running counts; a latch restarts them with this cycle's bit
  wire [31:0] bit_inc = {31'h00000000, bit_seen};
  wire [23:0] err_inc = {23'h000000, err_seen};
  wire bit_wrap = bit_seen & (&bit_cnt_reg);
  wire err_wrap = err_seen & (&err_cnt_reg);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= 32'h00000000;
      err_cnt_reg <= 24'h000000;
      bc_snap_reg <= 32'h00000000;
      ec_snap_reg <= 24'h000000;
    end else if (latch_rise) begin
      bc_snap_reg <= bit_cnt_reg;
      ec_snap_reg <= err_cnt_reg;
      bit_cnt_reg <= bit_inc;
      err_cnt_reg <= err_inc;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + bit_inc;
      err_cnt_reg <= err_cnt_reg + err_inc;
    end
  end

  // sticky events; a new event beats a read clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_ovf_reg <= 1'b0;
      err_ovf_reg <= 1'b0;
      bit_err_reg <= 1'b0;
      sync_chg_reg <= 1'b0;
    end else begin
      bit_ovf_reg <= bit_wrap | (bit_ovf_reg & ~st_clr);
      err_ovf_reg <= err_wrap | (err_ovf_reg & ~st_clr);
      bit_err_reg <= err_seen | (bit_err_reg & ~st_clr);
      sync_chg_reg <= sync_flip | (sync_chg_reg & ~st_clr);
    end
  end

  // interrupt request, each source behind its enable
  // registered, so it follows its flag by one cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (ie_of & (bit_ovf_reg | err_ovf_reg)) |
                 (ie_bed & bit_err_reg) |
                 (ie_sync & sync_chg_reg);
    end
  end

  // outputs straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_data = tx_data_reg;
  assign rx_locked = sync_reg == SYNC_LOCKED;
  assign irq = irq_reg;
endmodule : bpc_top

/* File: bpc_top_properties.sv */
`timescale 1ns/1ns
module bpc_top_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // streams and status
  input wire logic tx_bit_en,
  input wire logic tx_data,
  input wire logic rx_bit_en,
  input wire logic rx_data,
  input wire logic rx_locked,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // shadow of control zero, taken from completed writes
  logic [15:0] c0_reg;
  wire c0_wr = pready && pwrite && paddr == 12'h500;
  // the map is eight aligned words from 0x500
  wire unmapped = paddr[11:5] != 7'h28 || paddr[1:0] != 2'h0;
  // shadow follows the write edge, as the register does
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) c0_reg <= 16'h0000;
    else if (c0_wr) c0_reg <= pwdata[15:0];
  end
  property p_one_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("ready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held");
  property p_err_map;
    pready |-> pslverr == unmapped;
  endproperty
  a_err_map: assert property (p_err_map)
    else $error("error flag wrong");
  property p_hi_zero;
    pready && !pwrite |-> prdata[31:16] == 16'h0000;
  endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("upper half set");
  property p_resync;
    c0_wr && pwdata[0] && !c0_reg[0] |-> ##[1:3] !rx_locked;
  endproperty
  a_resync: assert property (p_resync)
    else $error("lock kept");
  property p_irq_mask;
    c0_reg[15:13] == 3'h0 && $past(c0_reg[15:13], 2) == 3'h0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("masked irq");
  property p_irq_cause;
    $rose(irq) |-> $past(c0_reg[15:13]) != 3'h0;
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq without enable");
  property p_tx_hold;
    !tx_bit_en |=> $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx moved");
endmodule : bpc_top_properties

bind bpc_top bpc_top_properties i_bpc_top_properties (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_bit_en(tx_bit_en),
  .tx_data(tx_data), .rx_bit_en(rx_bit_en), .rx_data(rx_data),
  .rx_locked(rx_locked), .irq(irq));

/* File: bpc_line_model.sv */
`timescale 1ns/1ns
module bpc_line_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // line pace, whole-line flip, one-bit error request
  input wire logic [3:0] gap,
  input wire logic flip,
  input wire logic hit,
  // device side
  input wire logic tx_data,
  output logic tx_bit_en,
  output logic rx_bit_en,
  output logic rx_data
);
  logic [3:0] cnt_reg; // bit pacing
  logic dly_reg; // tx bit now valid
  logic pend_reg; // error waiting for a bit
  // loop each sent bit back two cycles after its enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      tx_bit_en <= 1'b0;
      dly_reg <= 1'b0;
      pend_reg <= 1'b0;
      rx_bit_en <= 1'b0;
      rx_data <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg >= gap) ? 4'h0 : cnt_reg + 4'h1;
      tx_bit_en <= cnt_reg == 4'h0;
      dly_reg <= tx_bit_en;
      rx_bit_en <= dly_reg;
      pend_reg <= dly_reg ? 1'b0 : (pend_reg | hit);
      // between bits the line shows the inverse, never a stale copy
      rx_data <= dly_reg ? (tx_data ^ flip ^ pend_reg ^ hit) : ~rx_data;
    end
  end
endmodule : bpc_line_model

/* File: bert_pattern_control_bench.sv */
`timescale 1ns/1ns
module bert_pattern_control_bench;
  logic sys_clk, rst_n, psel, penable, pwrite, hit, flip;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, tx_bit_en, tx_data, rx_bit_en, rx_data;
  logic rx_locked, irq;
  logic [3:0] gap;
  int n_fail = 0;
  int total_checks = 0;
  int c0_m; // model of control zero
  int err_m; // model of errors since latch
  bpc_top i_bpc_top (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_bit_en(tx_bit_en), .tx_data(tx_data), .rx_bit_en(rx_bit_en),
    .rx_data(rx_data), .rx_locked(rx_locked), .irq(irq));
  bpc_line_model i_bpc_line_model (.sys_clk(sys_clk), .rst_n(rst_n),
    .gap(gap), .flip(flip), .hit(hit), .tx_data(tx_data),
    .tx_bit_en(tx_bit_en), .rx_bit_en(rx_bit_en), .rx_data(rx_data));
  // free running clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk
  // one apb transfer; the request holds until ready is sampled
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (n >= 50) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x,
      input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd_chk
  // bounded wait for lock; a lock that must not come waits it out
  task automatic wait_lock(input int lim, input logic x);
    int n;
    n = 0;
    while (rx_locked !== x && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (!x) repeat (lim) @(posedge sys_clk);
    chk({31'h0, rx_locked}, {31'h0, x});
  endtask : wait_lock
  // pattern, tx load edge, select, then resync edge
  task automatic set_mode(input int ps, input logic [15:0] inv);
    logic [31:0] p;
    p = (ps == 4) ? 32'h5AD6B5AD : (ps == 5) ? 32'h3C5AA5C3 : 32'hFFFFFFFF;
    wr(12'h508, {16'h0, p[15:0]});
    wr(12'h50C, {16'h0, p[31:16]});
    wr(12'h504, 32'h0500);
    wr(12'h504, 32'h0501);
    c0_m = (ps << 2) | 32'h0D00 | inv; // length 30, five repeats of each 16-bit word
    wr(12'h500, c0_m);
    wr(12'h500, c0_m | 1);
    repeat (3) @(posedge sys_clk);
  endtask : set_mode
  task automatic inject(input int k);
    repeat (k) begin
      hit <= 1'b1;
      @(posedge sys_clk);
      hit <= 1'b0;
      repeat (20) @(posedge sys_clk);
      err_m++;
    end
  endtask : inject
  // hang guard, well past the longest expected run
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end
  initial begin
    int v;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    gap = 4'h0;
    flip = 1'b0;
    hit = 1'b0;
    rst_n = 1'b0;
    v = $urandom(32'hEFF0);
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // all registers start at zero, the word past the map is refused
    for (int i = 0; i < 9; i++)
      rd_chk(12'h500 + 12'(4 * i), 0, i == 8);
    // random control words, reserved bits read zero
    repeat (4) begin
      v = $urandom;
      v[4:2] = 3'($urandom_range(5));
      v[0] = 1'b0; // resync waits until the select has settled
      wr(12'h500, v);
      rd_chk(12'h500, v & 32'hEF7F, 1'b0);
      wr(12'h504, v);
      rd_chk(12'h504, v & 32'hFF01, 1'b0);
    end
    // every legal code locks on a looped line at varied pace
    for (int i = 0; i < 6; i++) begin
      gap <= 4'(i);
      set_mode(i, 16'h0000);
      wait_lock(5000, 1'b1);
    end
    // a flipped line is followed with receive invert or transmit invert set
    gap <= 4'h1;
    flip <= 1'b1;
    set_mode(0, 16'h0000);
    wait_lock(2000, 1'b0);
    set_mode(0, 16'h0020);
    wait_lock(5000, 1'b1);
    set_mode(0, 16'h0040);
    wait_lock(5000, 1'b1);
    // open a window, two errors, latch, then a held latch bit
    c0_m = c0_m | 32'h4000;
    wr(12'h500, c0_m | 2);
    wr(12'h500, c0_m);
    err_m = 0;
    inject(2);
    chk({31'h0, irq}, 32'h1);
    wr(12'h500, c0_m | 2);
    rd_chk(12'h518, (err_m << 8) | 32'h19, 1'b0);
    wr(12'h500, c0_m | 2);
    rd_chk(12'h518, (err_m << 8) | 32'h01, 1'b0);
    chk({31'h0, irq}, 32'h0);
    rd_chk(12'h51C, 32'h0, 1'b0);
    rd_chk(12'h514, 32'h0, 1'b0);
    wr(12'h500, c0_m);
    wr(12'h500, c0_m | 2);
    rd_chk(12'h518, 32'h0001, 1'b0);
    // with the enable clear an error raises nothing
    wr(12'h500, c0_m & 32'hBFFF);
    inject(1);
    chk({31'h0, irq}, 32'h0);
    // the flag was kept while masked; enabling shows it a cycle later
    wr(12'h500, c0_m);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    complete_run();
  end
endmodule : bert_pattern_control_bench
